/* File: pkg/ibp_pkg.sv */
// shared types and constants for the serial bridge slave port
package ibp_pkg;

    // ------------------------------------------------------------
    // clock and bit timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;       // 40 MHz system clock
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] BIT_CNT_RST = 4'h0;
    localparam int ADDR_W = 7;

    // ------------------------------------------------------------
    // reset values and fill data
    // ------------------------------------------------------------
    localparam logic [7:0] SHIFT_RST = 8'h00;
    localparam logic [7:0] TX_FILL_BYTE = 8'hff;  // sent when host queue empty
    localparam logic PIN_IDLE = 1'b1;             // released bus reads high

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic scl;
        logic sda;
        logic bus_voltage_sense;
    } ibp_pins_t;

    typedef struct packed {
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
    } ibp_events_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_RX,
        ST_RX_ACK,
        ST_TX,
        ST_TX_ACK,
        ST_WAIT
    } ibp_state_t;

endpackage : ibp_pkg

/* File: src/ibp_pin_sync.sv */
// pin synchroniser with scl edge and start/stop detection
`timescale 1ns/1ps
module ibp_pin_sync (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire ibp_pkg::ibp_pins_t pins_i,
    output ibp_pkg::ibp_pins_t pins_o,
    output ibp_pkg::ibp_events_t events_o
);
    ibp_pkg::ibp_pins_t meta_r;
    ibp_pkg::ibp_pins_t sync_r;
    ibp_pkg::ibp_pins_t prev_r;
    localparam ibp_pkg::ibp_pins_t PINS_RST = '{
        scl: ibp_pkg::PIN_IDLE, sda: ibp_pkg::PIN_IDLE,
        bus_voltage_sense: 1'b0};

    // ------------------------------------------------------------
    // two-flop sync, third stage only for edge finding
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            meta_r <= PINS_RST;
            sync_r <= PINS_RST;
            prev_r <= PINS_RST;
        end else begin
            meta_r <= pins_i;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign pins_o = sync_r;
    // sda edges while scl stays high mark start and stop
    assign events_o.scl_rise = sync_r.scl & ~prev_r.scl;
    assign events_o.scl_fall = ~sync_r.scl & prev_r.scl;
    assign events_o.start = sync_r.scl & prev_r.scl &
        prev_r.sda & ~sync_r.sda;
    assign events_o.stop = sync_r.scl & prev_r.scl &
        ~prev_r.sda & sync_r.sda;

endmodule : ibp_pin_sync

/* File: src/ibp_slave_port.sv */
// serial-bus slave port of the usb bridge with power control
`timescale 1ns/1ps
// Function
// - device is slave only; master supplies scl, sda is two-way
// - works at 100k, 400k, 1M and 3.4M bus rates
// - after start: seven address bits then direction bit, 0 write 1 read
// - on address match pull sda low for ninth clock, else stay silent
// - once addressed receive on write, transmit on read
// - address and data shift most significant bit first
// - sda fall with scl high is start, sda rise is stop
// - acknowledge every byte received during a master write; code nacks a byte while the holding register is still full
// - repeated start without stop decodes a fresh address
// - own address comes from nonvolatile configuration memory
// - no bus voltage: stay suspended, data-plus pull-up off
// - in reset interface pins float, inputs weakly high
// - active-low power enable off before enumeration and in suspend
// - bytes written by master go to the host unframed
// - bytes from host are handed to master on reads
module ibp_slave_port (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic [ibp_pkg::ADDR_W-1:0] slave_addr_i,
    input wire logic pd_on_suspend_i,
    input wire logic bus_voltage_sense_i,
    input wire logic usb_configured_i,
    input wire logic usb_suspend_i,
    output logic usb_data_plus_pin_o,
    output logic power_enable_n_o,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o
);
    ibp_pkg::ibp_pins_t pins_s;
    ibp_pkg::ibp_events_t ev;
    ibp_pkg::ibp_state_t state_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] rx_data_r;
    logic rx_valid_r;
    logic read_r;
    logic nack_r;
    logic sda_low_r;
    logic pullup_r;
    logic pwr_n_r;
    logic suspended;
    logic addr_hit;
    logic byte_done;
    logic load_tx;

    // ------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------
    // pins are asynchronous to ref_clk; at 40 MHz the 3.4M high phase
    // is only a couple of samples, so that rate is the tight corner
    ibp_pin_sync u_sync (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .pins_i('{scl: scl_i, sda: sda_i,
                  bus_voltage_sense: bus_voltage_sense_i}),
        .pins_o(pins_s),
        .events_o(ev)
    );

    // decode helpers
    assign suspended = ~pins_s.bus_voltage_sense | usb_suspend_i;
    assign addr_hit = (shift_r[7:1] == slave_addr_i);
    assign byte_done = ev.scl_fall & (bit_cnt_r == ibp_pkg::BITS_PER_BYTE);
    // a read byte is taken from the host side after the read address ack and after each master ack
    assign load_tx = ev.scl_fall & ~suspended & ~ev.start & ~ev.stop &
        (((state_r == ibp_pkg::ST_ADDR_ACK) & read_r) |
         ((state_r == ibp_pkg::ST_TX_ACK) & ~nack_r));
    assign tx_ready_o = load_tx;

    // ------------------------------------------------------------
    // protocol state machine
    // ------------------------------------------------------------
    // scl is never driven: progress only follows master edges
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            state_r <= ibp_pkg::ST_IDLE;
            bit_cnt_r <= ibp_pkg::BIT_CNT_RST;
            shift_r <= ibp_pkg::SHIFT_RST;
            read_r <= 1'b0;
            nack_r <= 1'b0;
        end else if (suspended) begin
            state_r <= ibp_pkg::ST_IDLE;
            bit_cnt_r <= ibp_pkg::BIT_CNT_RST;
        end else if (ev.start) begin
            // repeated start restarts address decode mid-message
            state_r <= ibp_pkg::ST_ADDR;
            bit_cnt_r <= ibp_pkg::BIT_CNT_RST;
        end else if (ev.stop) begin
            state_r <= ibp_pkg::ST_IDLE;
        end else begin
            case (state_r)
                ibp_pkg::ST_ADDR, ibp_pkg::ST_RX: begin
                    if (ev.scl_rise) begin
                        shift_r <= {shift_r[6:0], pins_s.sda};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (byte_done) begin
                        bit_cnt_r <= ibp_pkg::BIT_CNT_RST;
                        if (state_r == ibp_pkg::ST_ADDR) begin
                            read_r <= shift_r[0];
                            state_r <= addr_hit ? ibp_pkg::ST_ADDR_ACK
                                                : ibp_pkg::ST_WAIT;
                        end else begin
                            // no room for the byte: refuse it with a nack
                            state_r <= rx_valid_r ? ibp_pkg::ST_WAIT
                                                  : ibp_pkg::ST_RX_ACK;
                        end
                    end
                end
                ibp_pkg::ST_ADDR_ACK: begin
                    if (ev.scl_fall) begin
                        if (read_r) begin
                            state_r <= ibp_pkg::ST_TX;
                            shift_r <= tx_valid_i ? tx_data_i
                                                  : ibp_pkg::TX_FILL_BYTE;
                        end else begin
                            state_r <= ibp_pkg::ST_RX;
                        end
                    end
                end
                ibp_pkg::ST_RX_ACK: begin
                    if (ev.scl_fall) begin
                        state_r <= ibp_pkg::ST_RX;
                    end
                end
                ibp_pkg::ST_TX: begin
                    if (ev.scl_rise) begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (byte_done) begin
                        bit_cnt_r <= ibp_pkg::BIT_CNT_RST;
                        state_r <= ibp_pkg::ST_TX_ACK;
                    end else if (ev.scl_fall) begin
                        shift_r <= {shift_r[6:0], 1'b0};
                    end
                end
                ibp_pkg::ST_TX_ACK: begin
                    if (ev.scl_rise) begin
                        nack_r <= pins_s.sda;
                    end else if (ev.scl_fall) begin
                        if (nack_r) begin
                            state_r <= ibp_pkg::ST_WAIT;
                        end else begin
                            state_r <= ibp_pkg::ST_TX;
                            shift_r <= tx_valid_i ? tx_data_i
                                                  : ibp_pkg::TX_FILL_BYTE;
                        end
                    end
                end
                default: begin
                    // idle only leaves on start, wait leaves on start or stop
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // sda drive (open drain: enable means pull low)
    // ------------------------------------------------------------
    // transmit bit is set up on scl fall so it is stable while scl high
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            sda_low_r <= 1'b0;
        end else if (suspended) begin
            sda_low_r <= pd_on_suspend_i;
        end else if (ev.start | ev.stop) begin
            sda_low_r <= 1'b0;
        end else if (ev.scl_fall) begin
            case (state_r)
                ibp_pkg::ST_ADDR:
                    sda_low_r <= (bit_cnt_r == ibp_pkg::BITS_PER_BYTE)
                                 & addr_hit;
                ibp_pkg::ST_RX:
                    sda_low_r <= (bit_cnt_r == ibp_pkg::BITS_PER_BYTE)
                                 & ~rx_valid_r;
                ibp_pkg::ST_ADDR_ACK:
                    sda_low_r <= read_r & (tx_valid_i ? ~tx_data_i[7]
                                 : ~ibp_pkg::TX_FILL_BYTE[7]);
                ibp_pkg::ST_TX:
                    sda_low_r <= (bit_cnt_r != ibp_pkg::BITS_PER_BYTE)
                                 & ~shift_r[6];
                ibp_pkg::ST_TX_ACK:
                    sda_low_r <= ~nack_r & (tx_valid_i ? ~tx_data_i[7]
                                 : ~ibp_pkg::TX_FILL_BYTE[7]);
                default:
                    sda_low_r <= 1'b0;
            endcase
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_o = sda_low_r;

    // ------------------------------------------------------------
    // received byte hand-off toward the host
    // ------------------------------------------------------------
    // single holding register; a byte is never overwritten, it is nacked
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            rx_valid_r <= 1'b0;
            rx_data_r <= ibp_pkg::SHIFT_RST;
        end else if (byte_done & (state_r == ibp_pkg::ST_RX) & ~rx_valid_r
                     & ~suspended & ~ev.start & ~ev.stop) begin
            rx_valid_r <= 1'b1;
            rx_data_r <= shift_r;
        end else if (rx_ready_i) begin
            rx_valid_r <= 1'b0;
        end
    end

    assign rx_data_o = rx_data_r;
    assign rx_valid_o = rx_valid_r;

    // ------------------------------------------------------------
    // usb power signalling
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            pullup_r <= 1'b0;
            pwr_n_r <= 1'b1;
        end else begin
            pullup_r <= pins_s.bus_voltage_sense;
            pwr_n_r <= ~(usb_configured_i & ~suspended);
        end
    end

    assign usb_data_plus_pin_o = pullup_r;
    assign power_enable_n_o = pwr_n_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    ack_on_match_a: assert property (
        (state_r == ibp_pkg::ST_ADDR) && byte_done && addr_hit &&
        !suspended && !ev.start && !ev.stop
        |=> sda_oe_o && (state_r == ibp_pkg::ST_ADDR_ACK))
        else $error("matching address not acknowledged");
    no_foreign_ack_a: assert property (
        (state_r == ibp_pkg::ST_ADDR) && byte_done && !addr_hit &&
        !suspended |=> !sda_oe_o [*2])
        else $error("foreign address acknowledged");
    start_decode_a: assert property (
        ev.start && !suspended
        |=> state_r == ibp_pkg::ST_ADDR && bit_cnt_r == 4'h0)
        else $error("start did not restart address decode");
    stop_idle_a: assert property (
        ev.stop && !suspended |=> state_r == ibp_pkg::ST_IDLE && !sda_oe_o)
        else $error("stop did not release the bus");
    rx_handoff_a: assert property (
        (state_r == ibp_pkg::ST_RX) && byte_done && !rx_valid_r &&
        !suspended && !ev.start && !ev.stop
        |=> rx_valid_o && rx_data_o == $past(shift_r) && sda_oe_o)
        else $error("received byte not handed on or not acked");
    nack_release_a: assert property (
        (state_r == ibp_pkg::ST_TX_ACK) && ev.scl_fall && nack_r &&
        !suspended && !ev.start && !ev.stop
        |=> state_r == ibp_pkg::ST_WAIT && !sda_oe_o)
        else $error("sda held after master nack");
    tx_msb_first_a: assert property (
        (state_r == ibp_pkg::ST_TX) && ev.scl_fall && !byte_done &&
        !suspended && !ev.start && !ev.stop
        |=> sda_oe_o == !$past(shift_r[6]))
        else $error("transmit bit order wrong");
    pullup_gate_a: assert property (
        !pins_s.bus_voltage_sense |=> !usb_data_plus_pin_o)
        else $error("data-plus pull-up on without bus voltage");
    pwr_off_suspend_a: assert property (
        suspended || !usb_configured_i |=> power_enable_n_o)
        else $error("power enable asserted in suspend");
    suspend_pd_a: assert property (
        suspended && !ev.start |=> sda_oe_o == $past(pd_on_suspend_i))
        else $error("suspend pull-down option not honoured");
    reset_float_a: assert property (@(posedge ref_clk_i) disable iff (1'b0)
        !reset_n_i |=> !sda_oe_o && !usb_data_plus_pin_o)
        else $error("pins driven during reset");

    write_seen_c: cover property (
        (state_r == ibp_pkg::ST_RX_ACK) ##[1:400] rx_valid_o);
    read_seen_c: cover property (
        (state_r == ibp_pkg::ST_TX_ACK) && ev.scl_fall && !nack_r);
    restart_seen_c: cover property (
        (state_r == ibp_pkg::ST_ADDR_ACK) ##[1:800] ev.start);
    read_end_c: cover property (state_r == ibp_pkg::ST_WAIT && read_r);

endmodule : ibp_slave_port

/* File: testbench/ibp_master_model.sv */
// bus master model that clocks the slave port and drives the data line
`timescale 1ns/1ps
module ibp_master_model (
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    // ------------------------------------------------------------
    // bit timing: 120 ns low, 80 ns high, 200 ns per bit
    // ------------------------------------------------------------
    localparam int T_LOW_A = 60;
    localparam int T_HIGH_A = 40;
    // pin moves sit off the system clock edge so sampling never races
    localparam int T_SKEW = 5;

    // idle bus: clock high, data released to the pull-up
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end

    // one bit; data moves only while the clock is low
    task automatic bit_xfer(input logic b, output logic r);
        #T_SKEW sda_oe_o = ~b;
        #(T_LOW_A - T_SKEW) scl_o = 1'b1;
        #(T_HIGH_A - T_SKEW) r = sda_i;
        #(T_HIGH_A + T_SKEW) scl_o = 1'b0;
        #T_LOW_A;
    endtask : bit_xfer

    // start, also used mid-message as a repeated start
    task automatic send_start();
        #T_SKEW sda_oe_o = 1'b0;
        #(T_LOW_A - T_SKEW) scl_o = 1'b1;
        #(T_HIGH_A - T_SKEW) sda_oe_o = 1'b1;
        #(T_HIGH_A + T_SKEW) scl_o = 1'b0;
        #T_LOW_A;
    endtask : send_start

    // stop leaves the bus idle with the clock parked high
    task automatic send_stop();
        #T_SKEW sda_oe_o = 1'b1;
        #(T_LOW_A - T_SKEW) scl_o = 1'b1;
        #(T_HIGH_A - T_SKEW) sda_oe_o = 1'b0;
        #(100 + T_SKEW);
    endtask : send_stop

    // byte out, then the slave's answer bit (0 = taken)
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(b[i], r);
        end
        bit_xfer(1'b1, ack);
    endtask : send_byte

    // byte in, then our own answer bit; 1 marks the last byte
    task automatic recv_byte(input logic ack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, b[i]);
        end
        bit_xfer(ack, r);
    endtask : recv_byte
endmodule : ibp_master_model

/* File: testbench/ibp_slave_port_tb.sv */
// self-checking bench for the serial bridge slave port
`timescale 1ns/1ps
module ibp_slave_port_tb;
    localparam logic [6:0] OWN_ADDR = 7'h3c;
    logic ref_clk = 1'b0;
    logic reset_n, scl, sda_w, dut_sda, dut_oe, m_oe, pd_on_suspend;
    logic sense, configured, suspend, dp_pin, pwr_en_n;
    logic rx_valid, tx_ready, ack;
    logic rx_ready = 1'b0;
    logic tx_valid = 1'b0;
    logic hold_rx = 1'b0;
    logic [7:0] rx_data, rd, b;
    logic [7:0] tx_data = 8'h00;
    logic [7:0] tv [3];
    logic [7:0] exp_q [$];
    logic [7:0] tx_q [$];
    int miscompares = 0;
    int total_checks = 0;
    int seed = 32'hc50a;

    // open-drain data wire with pull-up: either party may pull it low
    assign sda_w = (dut_oe ? dut_sda : 1'b1) & ~m_oe;
    always #12.5 ref_clk = ~ref_clk;

    ibp_slave_port dut_u (.ref_clk_i(ref_clk), .reset_n_i(reset_n),
        .scl_i(scl), .sda_i(sda_w), .sda_o(dut_sda), .sda_oe_o(dut_oe),
        .slave_addr_i(OWN_ADDR), .pd_on_suspend_i(pd_on_suspend),
        .bus_voltage_sense_i(sense), .usb_configured_i(configured),
        .usb_suspend_i(suspend), .usb_data_plus_pin_o(dp_pin),
        .power_enable_n_o(pwr_en_n), .rx_data_o(rx_data),
        .rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .tx_data_i(tx_data),
        .tx_valid_i(tx_valid), .tx_ready_o(tx_ready));
    ibp_master_model master_u (.sda_i(sda_w), .scl_o(scl), .sda_oe_o(m_oe));

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic close_out();
        if (miscompares == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    task automatic wait_clk(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : wait_clk

    // start plus address byte, answer compared with what is expected
    task automatic send_addr(input logic [6:0] a, input logic rw,
                             input logic exp_ack);
        logic k;
        master_u.send_start();
        master_u.send_byte({a, rw}, k);
        check({7'h00, k}, {7'h00, exp_ack});
    endtask : send_addr

    // ------------------------------------------------------------
    // host-side consumer and producer
    // ------------------------------------------------------------
    // random readiness stalls the consumer; hold_rx stops it so the holder fills
    always @(posedge ref_clk) begin
        rx_ready <= hold_rx ? 1'b0 : 1'($random(seed));
        if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
            if (exp_q.size() > 0) begin
                check(rx_data, exp_q.pop_front());
            end else begin
                check(rx_data, ~rx_data);
            end
        end
    end

    // tx queue head is offered; the pulse on tx_ready consumes it
    always @(posedge ref_clk) begin
        if (tx_ready === 1'b1 && tx_valid === 1'b1) begin
            void'(tx_q.pop_front());
        end
        tx_valid <= (tx_q.size() > 0);
        tx_data <= (tx_q.size() > 0) ? tx_q[0] : 8'h00;
    end

    // hang guard: a stuck run ends as a failure
    initial begin
        wait_clk(100000);
        miscompares++;
        close_out();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        reset_n = 1'b0;
        sense = 1'b0;
        configured = 1'b0;
        suspend = 1'b0;
        pd_on_suspend = 1'b0;
        wait_clk(12);
        reset_n <= 1'b1;
        wait_clk(8);
        check({6'h00, dp_pin, pwr_en_n}, 8'h01);
        sense <= 1'b1;
        wait_clk(8);
        check({6'h00, dp_pin, pwr_en_n}, 8'h03);
        configured <= 1'b1;
        wait_clk(4);
        check({6'h00, dp_pin, pwr_en_n}, 8'h02);
        // burst of writes, every byte must be taken, then a write to a foreign address is nacked
        send_addr(OWN_ADDR, 1'b0, 1'b0);
        for (int i = 0; i < 3; i++) begin
            b = 8'($random(seed));
            exp_q.push_back(b);
            master_u.send_byte(b, ack);
            check({7'h00, ack}, 8'h00);
        end
        master_u.send_stop();
        send_addr(OWN_ADDR ^ 7'h01, 1'b0, 1'b1);
        master_u.send_byte(8'h5a, ack);
        check({7'h00, ack}, 8'h01);
        master_u.send_stop();
        // read two, then clock a byte after our nack: bus must stay high
        for (int i = 0; i < 3; i++) begin
            tv[i] = 8'($random(seed));
            tx_q.push_back(tv[i]);
        end
        send_addr(OWN_ADDR, 1'b1, 1'b0);
        master_u.recv_byte(1'b0, rd);
        check(rd, tv[0]);
        master_u.recv_byte(1'b1, rd);
        check(rd, tv[1]);
        master_u.recv_byte(1'b1, rd);
        check(rd, 8'hff);
        master_u.send_stop();
        // combined message: write then read with no stop between
        send_addr(OWN_ADDR, 1'b0, 1'b0);
        b = 8'($random(seed));
        exp_q.push_back(b);
        master_u.send_byte(b, ack);
        check({7'h00, ack}, 8'h00);
        send_addr(OWN_ADDR, 1'b1, 1'b0);
        master_u.recv_byte(1'b1, rd);
        check(rd, tv[2]);
        // empty host queue hands out the fill byte
        send_addr(OWN_ADDR, 1'b1, 1'b0);
        master_u.recv_byte(1'b1, rd);
        check(rd, ibp_pkg::TX_FILL_BYTE);
        master_u.send_stop();
        // stalled consumer: the holder is full, the next byte is refused
        hold_rx <= 1'b1;
        send_addr(OWN_ADDR, 1'b0, 1'b0);
        b = 8'($random(seed));
        exp_q.push_back(b);
        master_u.send_byte(b, ack);
        check({7'h00, ack}, 8'h00);
        master_u.send_byte(8'ha5, ack);
        check({7'h00, ack}, 8'h01);
        master_u.send_stop();
        hold_rx <= 1'b0;
        wait_clk(40);
        check(8'(exp_q.size()), 8'h00);
        // usb suspend alone: power switched off, pull-up stays on, no acknowledge
        suspend <= 1'b1;
        wait_clk(4);
        check({6'h00, dp_pin, pwr_en_n}, 8'h03);
        send_addr(OWN_ADDR, 1'b0, 1'b1);
        master_u.send_stop();
        suspend <= 1'b0;
        wait_clk(4);
        // power loss and suspend
        sense <= 1'b0;
        wait_clk(8);
        check({7'h00, dp_pin}, 8'h00);
        send_addr(OWN_ADDR, 1'b0, 1'b1);
        master_u.send_stop();
        wait_clk(1);
        pd_on_suspend <= 1'b1;
        suspend <= 1'b1;
        wait_clk(6);
        check({6'h00, dut_oe, pwr_en_n}, 8'h03);
        pd_on_suspend <= 1'b0;
        wait_clk(6);
        check({7'h00, dut_oe}, 8'h00);
        close_out();
    end
endmodule : ibp_slave_port_tb
